// *** rtl/iepr_regs.svh ***
// Purpose: Register offsets, field positions, reset values for the interrupt enable/priority block
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   Definitions only
`ifndef IEPR_REGS_SVH
`define IEPR_REGS_SVH

// -----------------------------------------------------------------------------
// Register byte offsets
// -----------------------------------------------------------------------------
`define IEPR_ENABLE_MASK_OFS      8'ha8   // interrupt_enable_mask
`define IEPR_PRIORITY_SELECT_OFS  8'hb8   // interrupt_priority_select
`define IEPR_PENDING_STATUS_OFS   8'hc0   // Gated pending requests, read only
`define IEPR_SERVICE_STATUS_OFS   8'hc4   // Service state and current source, read only

// -----------------------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------------------
`define IEPR_ENABLE_MASK_RST      7'h00
`define IEPR_PRIORITY_SELECT_RST  7'h00
`define IEPR_PRIORITY_BIT7_VAL    1'b1    // Unused top priority bit reads one

// -----------------------------------------------------------------------------
// Source positions (also fixed ordering, lowest index first)
// -----------------------------------------------------------------------------
`define IEPR_SRC_EXT0    0
`define IEPR_SRC_TIMER0  1
`define IEPR_SRC_EXT1    2
`define IEPR_SRC_TIMER1  3
`define IEPR_SRC_SERIAL  4
`define IEPR_SRC_TIMER2  5
`define IEPR_SRC_SPI     6
`define IEPR_NUM_SRC     7

`endif

// *** rtl/iepr_pkg.sv ***
// Purpose: Types shared by the interrupt enable/priority block
// Assumes: Nothing beyond SystemVerilog packages
// Notes:   Constants live in iepr_regs.svh
package iepr_pkg;

	// -------------------------------------------------------------------------
	// Service nesting state, one-hot
	// -------------------------------------------------------------------------
	typedef enum logic [3:0]
	{
		SVC_IDLE = 4'b0001,   // Nothing in service
		SVC_LOW  = 4'b0010,   // Low-level handler running
		SVC_HIGH = 4'b0100,   // High-level handler, nothing underneath
		SVC_NEST = 4'b1000    // High-level handler preempted a low one
	} iepr_svc_e;

	typedef logic [2:0] iepr_src_t;   // Source number

endpackage : iepr_pkg

// *** rtl/iepr_top.sv ***
// Purpose: Interrupt enable masking and two-level priority selection
// Assumes: APB slave, zero wait states; core acks and ends service by pulses
// Notes:   Requests of equal level resolve by fixed source order
//
// Notes on behaviour
// R1: Timer-1 enable bit three gates timer-1 overflow
// R2: Enable bit two gates external input one
// R3: Priority bit six sets SPI level
// R4: Priority bit four sets serial port level
// R5: High preempts low; fixed order within level
`timescale 1ns/1ps
`include "iepr_regs.svh"
`default_nettype none

module iepr_top
(
	input  wire logic               pclk,                      // System clock, 25 MHz
	input  wire logic               presetn,                   // Async reset, active low
	input  wire logic               psel,                      // APB select
	input  wire logic               penable,                   // APB access phase
	input  wire logic               pwrite,                    // APB direction
	input  wire logic [7:0]         paddr,                     // APB byte address
	input  wire logic [31:0]        pwdata,                    // APB write data
	output logic      [31:0]        prdata,                    // APB read data
	output logic                    pready,                    // APB ready
	output logic                    pslverr,                   // APB error, unmapped address
	input  wire logic               ext_input0_pend,           // External input 0 pending
	input  wire logic               timer0_overflow_flag,      // Timer 0 overflow
	input  wire logic               ext_irq_input_1,           // External input 1 request
	input  wire logic               timer1_overflow_flag,      // Timer 1 overflow
	input  wire logic               serial_rx_flag,            // Serial port receive done
	input  wire logic               serial_tx_flag,            // Serial port transmit done
	input  wire logic               timer2_low_overflow_flag,  // Timer 2 low byte overflow
	input  wire logic               timer2_high_overflow_flag, // Timer 2 high byte overflow
	input  wire logic [3:0]         spi_flags,                 // SPI event flags
	output logic                    irq_req,                   // Request to the core
	output logic                    irq_level,                 // Level of request, 1 = high
	output logic      [2:0]         irq_source,                // Source number of request
	input  wire logic               irq_ack,                   // Core takes request, pulse
	input  wire logic               irq_done                   // Core ends handler, pulse
);

	// -------------------------------------------------------------------------
	// Declarations
	// -------------------------------------------------------------------------
	localparam int NSRC = `IEPR_NUM_SRC;

	logic [NSRC-1:0]      en_r;          // Per-source enable bits
	logic [NSRC-1:0]      prio_r;        // Per-source priority bits
	logic [NSRC-1:0]      raw_pend;      // Pending flags per source
	logic [NSRC-1:0]      gated;         // Enabled pending flags
	logic [NSRC-1:0]      cand_hi;       // Enabled high-level requests
	logic [NSRC-1:0]      cand_lo;       // Enabled low-level requests
	iepr_pkg::iepr_svc_e  svc_r;         // Service nesting state
	iepr_pkg::iepr_svc_e  svc_nxt;       // Next service state
	iepr_pkg::iepr_src_t  pick_hi;       // Winner among high requests
	iepr_pkg::iepr_src_t  pick_lo;       // Winner among low requests
	logic                 req_nxt;       // Next request strobe
	logic                 lvl_nxt;       // Next request level
	iepr_pkg::iepr_src_t  src_nxt;       // Next request source
	iepr_pkg::iepr_src_t  cur_src_r;     // Source taken last by the core
	logic                 setup;         // APB setup cycle
	logic                 wr_en;         // APB write commits
	logic [31:0]          rd_val;        // Decoded read value
	logic                 bad_addr;      // Address not mapped

	// -------------------------------------------------------------------------
	// Source flags
	// -------------------------------------------------------------------------

	// Collect each peripheral's flags into one pending bit
	always_comb
	begin
		raw_pend                      = '0;
		raw_pend[`IEPR_SRC_EXT0]      = ext_input0_pend;
		raw_pend[`IEPR_SRC_TIMER0]    = timer0_overflow_flag;
		raw_pend[`IEPR_SRC_EXT1]      = ext_irq_input_1;
		raw_pend[`IEPR_SRC_TIMER1]    = timer1_overflow_flag;
		raw_pend[`IEPR_SRC_SERIAL]    = serial_rx_flag | serial_tx_flag;
		raw_pend[`IEPR_SRC_TIMER2]    = timer2_low_overflow_flag | timer2_high_overflow_flag;
		raw_pend[`IEPR_SRC_SPI]       = |spi_flags;
	end

	// Mask and split per source by its priority bit
	genvar gi;
	generate
		for (gi = 0; gi < NSRC; gi++)
		begin : g_src
			assign gated[gi]   = raw_pend[gi] & en_r[gi];   // see R1, see R2
			assign cand_hi[gi] = gated[gi] & prio_r[gi];    // see R3, see R4
			assign cand_lo[gi] = gated[gi] & ~prio_r[gi];   // see R3, see R4
		end
	endgenerate

	// -------------------------------------------------------------------------
	// Fixed-order selection
	// -------------------------------------------------------------------------

	// Lowest set index wins
	function automatic iepr_pkg::iepr_src_t first_set(input logic [NSRC-1:0] v);
		iepr_pkg::iepr_src_t r;
		r = '0;
		for (int k = NSRC - 1; k >= 0; k--)
		begin
			if (v[k])
			begin
				r = iepr_pkg::iepr_src_t'(k);
			end
		end
		return r;
	endfunction : first_set

	assign pick_hi = first_set(cand_hi);   // see R5
	assign pick_lo = first_set(cand_lo);   // see R5

	// Offer a request only above the level now in service
	always_comb
	begin
		req_nxt = 1'b0;
		lvl_nxt = 1'b0;
		src_nxt = '0;
		if ((|cand_hi) && (svc_r == iepr_pkg::SVC_IDLE || svc_r == iepr_pkg::SVC_LOW))
		begin
			// High level preempts a running low handler
			req_nxt = 1'b1;   // see R5
			lvl_nxt = 1'b1;
			src_nxt = pick_hi;
		end
		else if ((|cand_lo) && svc_r == iepr_pkg::SVC_IDLE)
		begin
			// Low level only when nothing is in service
			req_nxt = 1'b1;
			src_nxt = pick_lo;
		end
	end

	// Request outputs from flops, refreshed every cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq_req    <= 1'b0;
			irq_level  <= 1'b0;
			irq_source <= 3'h0;
		end
		else
		begin
			// A cycle of ack drops the request until service state settles
			irq_req    <= req_nxt & ~(irq_ack & irq_req);
			irq_level  <= lvl_nxt;
			irq_source <= src_nxt;
		end
	end

	// -------------------------------------------------------------------------
	// Service nesting
	// -------------------------------------------------------------------------

	// Next state on ack of the offered request or end of handler
	always_comb
	begin
		svc_nxt = svc_r;
		if (irq_ack && irq_req)
		begin
			unique case (svc_r)
				iepr_pkg::SVC_IDLE: svc_nxt = irq_level ? iepr_pkg::SVC_HIGH : iepr_pkg::SVC_LOW;
				iepr_pkg::SVC_LOW:  svc_nxt = iepr_pkg::SVC_NEST;   // see R5
				iepr_pkg::SVC_HIGH: svc_nxt = iepr_pkg::SVC_HIGH;
				iepr_pkg::SVC_NEST: svc_nxt = iepr_pkg::SVC_NEST;
			endcase
		end
		else if (irq_done)
		begin
			unique case (svc_r)
				iepr_pkg::SVC_IDLE: svc_nxt = iepr_pkg::SVC_IDLE;
				iepr_pkg::SVC_LOW:  svc_nxt = iepr_pkg::SVC_IDLE;
				iepr_pkg::SVC_HIGH: svc_nxt = iepr_pkg::SVC_IDLE;
				iepr_pkg::SVC_NEST: svc_nxt = iepr_pkg::SVC_LOW;   // Resume preempted handler
			endcase
		end
	end

	// Service state register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			svc_r <= iepr_pkg::SVC_IDLE;
		end
		else
		begin
			svc_r <= svc_nxt;
		end
	end

	// Remember which source the core took last
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cur_src_r <= '0;
		end
		else if (irq_ack && irq_req)
		begin
			cur_src_r <= irq_source;
		end
	end

	// -------------------------------------------------------------------------
	// APB slave
	// -------------------------------------------------------------------------
	assign setup  = psel & ~penable;
	assign pready = penable;                        // Zero wait states
	assign wr_en  = psel & penable & pwrite;

	// Read decode
	always_comb
	begin
		rd_val   = 32'h0000_0000;
		bad_addr = 1'b0;
		unique case (paddr)
			`IEPR_ENABLE_MASK_OFS:     rd_val[NSRC-1:0] = en_r;
			`IEPR_PRIORITY_SELECT_OFS: rd_val[7:0] = {`IEPR_PRIORITY_BIT7_VAL, prio_r};
			`IEPR_PENDING_STATUS_OFS:  rd_val[NSRC-1:0] = gated;
			`IEPR_SERVICE_STATUS_OFS:  rd_val[6:0] = {cur_src_r, svc_r};
			default:                   bad_addr = 1'b1;
		endcase
	end

	// Read data and error latched in setup, stable through access
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else if (setup)
		begin
			prdata  <= pwrite ? 32'h0000_0000 : rd_val;
			pslverr <= bad_addr;
		end
	end

	// Enable mask register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			en_r <= `IEPR_ENABLE_MASK_RST;
		end
		else if (wr_en && paddr == `IEPR_ENABLE_MASK_OFS)
		begin
			en_r <= pwdata[NSRC-1:0];   // see R1, see R2
		end
	end

	// Priority select register, top bit not writable
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prio_r <= `IEPR_PRIORITY_SELECT_RST;
		end
		else if (wr_en && paddr == `IEPR_PRIORITY_SELECT_OFS)
		begin
			prio_r <= pwdata[NSRC-1:0];   // see R3, see R4
		end
	end

	// -------------------------------------------------------------------------
	// Assertions
	// -------------------------------------------------------------------------
	property p_timer1_masked;
		@(posedge pclk) disable iff (!presetn)
		(irq_req && irq_source == 3'h3) |-> $past(en_r[3]) && $past(timer1_overflow_flag);
	endproperty
	a_timer1_masked: assert property (p_timer1_masked)   // see R1
		else $error("Timer 1 request while masked or not pending");

	property p_ext1_masked;
		@(posedge pclk) disable iff (!presetn)
		(!en_r[2] && !wr_en) |=> !(irq_req && irq_source == 3'h2);
	endproperty
	a_ext1_masked: assert property (p_ext1_masked)   // see R2
		else $error("External input 1 request passed a cleared enable");

	property p_spi_level;
		@(posedge pclk) disable iff (!presetn)
		(irq_req && irq_source == 3'h6) |-> irq_level == $past(prio_r[6]);
	endproperty
	a_spi_level: assert property (p_spi_level)   // see R3
		else $error("SPI request level differs from priority bit six");

	property p_serial_level;
		@(posedge pclk) disable iff (!presetn)
		(irq_req && irq_source == 3'h4) |-> irq_level == $past(prio_r[4]);
	endproperty
	a_serial_level: assert property (p_serial_level)   // see R4
		else $error("Serial port request level differs from priority bit four");

	property p_preempt;
		@(posedge pclk) disable iff (!presetn)
		(svc_r == iepr_pkg::SVC_LOW && |cand_hi && !irq_ack) |=> irq_req && irq_level;
	endproperty
	a_preempt: assert property (p_preempt)   // see R5
		else $error("High request failed to preempt low service");

	property p_order;
		@(posedge pclk) disable iff (!presetn)
		(svc_r == iepr_pkg::SVC_IDLE && !irq_ack && cand_hi[4] && cand_hi[6]) |=> irq_source == 3'h4;
	endproperty
	a_order: assert property (p_order)   // see R5
		else $error("Fixed source order not kept");

	property p_no_lower;
		@(posedge pclk) disable iff (!presetn)
		(svc_r == iepr_pkg::SVC_HIGH || svc_r == iepr_pkg::SVC_NEST) |=> !irq_req;
	endproperty
	a_no_lower: assert property (p_no_lower)   // see R5
		else $error("Request offered during high-level service");

endmodule : iepr_top

`default_nettype wire

// *** testbench/iepr_core_model.sv ***
// Purpose: Core side of the request and acknowledge handshake
// Assumes: irq_req is a registered level; ack and done are one-cycle pulses
// Notes:   Acks after ack_dly cycles while ack_en is high; done on bench command
`timescale 1ns/1ps
`default_nettype none

module iepr_core_model
(
	input  wire logic       pclk,      // System clock
	input  wire logic       presetn,   // Async reset, active low
	input  wire logic       irq_req,   // Request from the block
	input  wire logic       ack_en,    // Core may take requests
	input  wire logic [3:0] ack_dly,   // Cycles before taking, prompt or slow
	input  wire logic       done_go,   // Bench asks to end the inner handler
	output logic            irq_ack,   // Take pulse
	output logic            irq_done,  // End pulse
	output logic      [7:0] taken_cnt  // Requests taken so far
);
	logic [3:0] wait_r;  // Delay counter while a request stands

	// -------------------------------------------------------------------------
	// Take pulse, only while the request is up and after the delay
	// -------------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq_ack   <= 1'b0;
			wait_r    <= 4'h0;
			taken_cnt <= 8'h00;
		end
		else if (irq_ack)
		begin
			irq_ack <= 1'b0;  // One cycle only
			wait_r  <= 4'h0;
		end
		else if (ack_en && irq_req)
		begin
			if (wait_r == ack_dly)
			begin
				irq_ack   <= 1'b1;
				taken_cnt <= taken_cnt + 8'h01;
			end
			else
				wait_r <= wait_r + 4'h1;
		end
		else
			wait_r <= 4'h0;
	end

	// End pulse, one cycle after the bench asks
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_done <= 1'b0;
		else
			irq_done <= done_go;
	end
endmodule : iepr_core_model
`default_nettype wire

// *** testbench/test_interrupt_enable_priority_regs.sv ***
// Purpose: Self-checking bench for enable masking and priority selection
// Assumes: Zero-wait APB slave; core model takes requests on command
// Notes:   Flags are levels; alt picks the second flag of shared sources, SPI flags one to three
`timescale 1ns/1ps
`include "iepr_regs.svh"
`default_nettype none

module test_interrupt_enable_priority_regs;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, err, irq_req, irq_level, irq_ack, irq_done;
	logic        ack_en = 0, done_go = 0, alt = 0;
	logic [2:0]  irq_source;
	logic [6:0]  f = 7'h00;                 // Pending flag per source
	logic [3:0]  ack_dly = 4'h0;
	logic [7:0]  taken_cnt, t0;
	logic [7:0]  pv [4] = '{8'h00, 8'h40, 8'h10, 8'h50};  // Priority settings
	logic [4:0]  pe [4] = '{5'h14, 5'h1e, 5'h1c, 5'h1c};  // {req, level, source}
	int          n_mismatch = 0, comparisons = 0, i, m;

	always #20 pclk = ~pclk;

	iepr_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ext_input0_pend(f[0]), .timer0_overflow_flag(f[1]), .ext_irq_input_1(f[2]),
		.timer1_overflow_flag(f[3]), .serial_rx_flag(f[4] & ~alt), .serial_tx_flag(f[4] & alt),
		.timer2_low_overflow_flag(f[5] & ~alt), .timer2_high_overflow_flag(f[5] & alt),
		.spi_flags({{3{f[6] & alt}}, f[6] & ~alt}), .irq_req(irq_req), .irq_level(irq_level),
		.irq_source(irq_source), .irq_ack(irq_ack), .irq_done(irq_done));

	iepr_core_model i_core (.pclk(pclk), .presetn(presetn), .irq_req(irq_req), .ack_en(ack_en),
		.ack_dly(ack_dly), .done_go(done_go), .irq_ack(irq_ack), .irq_done(irq_done),
		.taken_cnt(taken_cnt));

	// -------------------------------------------------------------------------
	// Report and compare
	// -------------------------------------------------------------------------
	task automatic end_sim();
		if (n_mismatch == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_sim

	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[ERR] %0t register got %h expected %h", $time, got, exp);
		end
	endtask : chk_reg

	task automatic chk_irq(input logic [4:0] exp);
		comparisons++;
		if ({irq_req, irq_level, irq_source} !== exp)
		begin
			n_mismatch++;
			$display("[ERR] %0t request got %h expected %h", $time, {irq_req, irq_level, irq_source}, exp);
		end
	endtask : chk_irq

	// -------------------------------------------------------------------------
	// Bus, handshake and wait helpers; all entered right after a rising edge
	// -------------------------------------------------------------------------
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
		begin
			n_mismatch++;
			end_sim();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic wait_irq();
		int n;
		for (n = 0; n < 20 && irq_req !== 1'b1; n++)
			@(posedge pclk);
		if (irq_req !== 1'b1)
		begin
			n_mismatch++;
			end_sim();
		end
	endtask : wait_irq

	task automatic take();
		int n;
		t0 = taken_cnt;
		ack_en <= 1'b1;
		for (n = 0; n < 30 && taken_cnt === t0; n++)
			@(posedge pclk);
		ack_en <= 1'b0;
		if (taken_cnt === t0)
		begin
			n_mismatch++;
			end_sim();
		end
		repeat (2) @(posedge pclk);
	endtask : take

	task automatic finish_handler();
		done_go <= 1'b1;
		@(posedge pclk);
		done_go <= 1'b0;
		repeat (2) @(posedge pclk);
	endtask : finish_handler

	task automatic chk_state(input logic [3:0] exp);
		apb(1'b0, `IEPR_SERVICE_STATUS_OFS, 32'h0);
		chk_reg({28'h0, rd[3:0]}, {28'h0, exp});
	endtask : chk_state

	// -------------------------------------------------------------------------
	// Main sequence
	// -------------------------------------------------------------------------
	initial
	begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		// Reset values, then an unmapped place
		apb(1'b0, `IEPR_ENABLE_MASK_OFS, 32'h0);
		chk_reg(rd, 32'h0);
		apb(1'b0, `IEPR_PRIORITY_SELECT_OFS, 32'h0);
		chk_reg(rd, 32'h80);
		chk_state(4'h1);
		apb(1'b0, 8'h10, 32'h0);
		chk_reg({err, rd[30:0]}, 32'h8000_0000);
		// Each source masked, then passed, with both flags of shared sources
		for (i = 0; i < 14; i++)
		begin
			m = 1 << (i / 2);
			alt <= i[0];
			f <= 7'(m);
			apb(1'b1, `IEPR_ENABLE_MASK_OFS, 32'h0);
			apb(1'b0, `IEPR_PENDING_STATUS_OFS, 32'h0);
			chk_reg(rd, 32'h0);
			chk_irq(5'h00);
			apb(1'b1, `IEPR_ENABLE_MASK_OFS, 32'hffff_ff00 | m);
			wait_irq();
			chk_irq({2'b10, 3'(i / 2)});
			apb(1'b0, `IEPR_ENABLE_MASK_OFS, 32'h0);
			chk_reg(rd, 32'(m));
		end
		// Serial and SPI both pending under every priority setting
		alt <= 1'b0;
		f <= 7'h50;
		apb(1'b1, `IEPR_ENABLE_MASK_OFS, 32'h50);
		for (i = 0; i < 4; i++)
		begin
			apb(1'b1, `IEPR_PRIORITY_SELECT_OFS, {24'h0, pv[i]});
			apb(1'b0, `IEPR_PRIORITY_SELECT_OFS, 32'h0);
			chk_reg(rd, {24'h0, pv[i] | 8'h80});
			wait_irq();
			chk_irq(pe[i]);
		end
		// Low handler, blocked low request, high preempts, nested return
		apb(1'b1, `IEPR_PRIORITY_SELECT_OFS, 32'h40);
		apb(1'b1, `IEPR_ENABLE_MASK_OFS, 32'h58);
		f <= 7'h10;
		ack_dly <= 4'h3;
		take();
		f <= 7'h08;
		chk_state(4'h2);
		repeat (4) @(posedge pclk);
		chk_irq(5'h00);
		f <= 7'h48;
		wait_irq();
		chk_irq(5'h1e);
		ack_dly <= 4'h0;
		take();
		f <= 7'h08;
		chk_state(4'h8);
		finish_handler();
		chk_state(4'h2);
		chk_irq(5'h00);
		finish_handler();
		chk_state(4'h1);
		wait_irq();
		chk_irq(5'h13);
		end_sim();
	end
endmodule : test_interrupt_enable_priority_regs
`default_nettype wire
